/* hw/fbsp_pkg.sv */
// Package for the flow-through burst memory port and its controller.
// Assumes a single 100 MHz clock shared by both ends.
package fbsp_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int BYTES = 4;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 32;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real CLOCK_TO_DATA_VALID_NS = 6.5;
  // Longest time rounds down, but never below one cycle
  localparam int CLOCK_TO_DATA_VALID_CYC =
    (int'(CLOCK_TO_DATA_VALID_NS / CLK_PERIOD_NS - 0.5) < 1) ? 1 :
    int'(CLOCK_TO_DATA_VALID_NS / CLK_PERIOD_NS - 0.5);
  // ----------------------------------------------------------------
  // Strap and reset values
  // ----------------------------------------------------------------
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic [BURST_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_ONE = 2'h1;
  // ----------------------------------------------------------------
  // Port access and controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FBSP_DESEL = 3'h1,
    FBSP_READ = 3'h2,
    FBSP_WRITE = 3'h4
  } fbsp_acc_t;
  typedef enum logic [2:0] {
    FBSP_C_IDLE = 3'h1,
    FBSP_C_CMD = 3'h2,
    FBSP_C_BURST = 3'h4
  } fbsp_cst_t;
endpackage : fbsp_pkg

/* hw/fbsp_bus_if.sv */
// Synchronous bus between memory controller and memory port.
// Two-way data lines are split into out, enable and resolved level.
`timescale 1ns/1ps
interface fbsp_bus_if;
  logic clock_qualifier_n;
  logic select_a_n;
  logic select_b;
  logic select_c_n;
  logic advance_or_load;
  logic write_n;
  logic output_drive_n;
  logic mode;
  logic [fbsp_pkg::ADDR_W-1:0] addr;
  logic [fbsp_pkg::BYTES-1:0] byte_lane_select_n;
  // Controller drive of data and parity
  logic [fbsp_pkg::DATA_W-1:0] ctl_dq;
  logic [fbsp_pkg::PAR_W-1:0] ctl_dqp;
  logic ctl_oe;
  // Memory drive of data and parity
  logic [fbsp_pkg::DATA_W-1:0] mem_dq;
  logic [fbsp_pkg::PAR_W-1:0] mem_dqp;
  logic mem_oe;
  // Resolved wire level
  logic [fbsp_pkg::DATA_W-1:0] dq;
  logic [fbsp_pkg::PAR_W-1:0] parity_lines;
  assign dq = mem_oe ? mem_dq : ctl_dq;
  assign parity_lines = mem_oe ? mem_dqp : ctl_dqp;

  modport mem (
    input clock_qualifier_n, select_a_n, select_b, select_c_n,
    input advance_or_load, write_n, output_drive_n, mode, addr,
    input byte_lane_select_n, dq, parity_lines,
    output mem_dq, mem_dqp, mem_oe
  );
  modport ctl (
    output clock_qualifier_n, select_a_n, select_b, select_c_n,
    output advance_or_load, write_n, output_drive_n, mode, addr,
    output byte_lane_select_n, ctl_dq, ctl_dqp, ctl_oe,
    input dq, parity_lines
  );
endinterface : fbsp_bus_if

/* hw/fbsp_mem.sv */
// Flow-through burst memory port with its storage array.
// Inputs are synchronous to clk_i; output drive enable is asynchronous.
//
// Summary of operation
// [RULE1] Strap low linear, high interleaved
// [RULE2] Inputs captured on rising clock edge
// [RULE3] Qualifier high freezes all internal state
// [RULE4] All selects, load low: latch address
// [RULE5] Write strobe low at start: write
// [RULE6] Controller presents read start conditions
// [RULE7] Read data flows out same cycle
// [RULE8] Controller holds output drive low
// [RULE9] New command right after read
// [RULE10] Any select inactive: deselect, float
// [RULE11] Burst counter gives four beats
// [RULE12] Load fresh address after deselect
// [RULE13] Counter steps two low bits, wraps
// [RULE14] Advance steps counter ignoring selects
// [RULE15] Direction held for whole burst
// [RULE16] Byte lanes gate partial writes
// [RULE17] All operations pipelined every edge
// [RULE18] Interleaved beat is start xor index
// [RULE19] Linear beat is start plus index
// [RULE20] Float during write, first, deselect
// [RULE21] Qualifier stretches cycle, no deselect
// [RULE22] Upper address fixed during burst
`timescale 1ns/1ps
module fbsp_mem #(
  parameter int ADDR_W = fbsp_pkg::ADDR_W,
  parameter int BYTES = fbsp_pkg::BYTES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Memory bus
  fbsp_bus_if.mem bus,
  // Status
  output logic busy_o
);
  localparam int BW = fbsp_pkg::BURST_W;
  localparam int DW = BYTES * 8;
  localparam int LANE_W = DW / BYTES;
  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  logic qualified;
  logic load_edge;
  logic advance_edge;
  logic selected;
  logic start;
  logic start_write;
  logic interleave;

  // A raised qualifier masks the edge entirely
  assign qualified = !bus.clock_qualifier_n; // RULE3 RULE21
  assign load_edge = qualified && !bus.advance_or_load;
  assign advance_edge = qualified && bus.advance_or_load; // RULE14
  assign selected = !bus.select_a_n && bus.select_b && !bus.select_c_n;
  assign start = load_edge && selected; // RULE4
  assign start_write = start && !bus.write_n; // RULE5
  assign interleave = (bus.mode != fbsp_pkg::MODE_LINEAR); // RULE1

  // ----------------------------------------------------------------
  // Access type
  // ----------------------------------------------------------------
  fbsp_pkg::fbsp_acc_t acc, next_acc;

  always_comb begin
    next_acc = acc;
    if (start) begin
      // Direction taken once per burst
      next_acc = start_write ? fbsp_pkg::FBSP_WRITE
                             : fbsp_pkg::FBSP_READ; // RULE5 RULE15
    end else if (load_edge) begin
      next_acc = fbsp_pkg::FBSP_DESEL; // RULE10
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin // RULE2 RULE17
    if (!resetn_i) begin
      acc <= fbsp_pkg::FBSP_DESEL;
    end else begin
      acc <= next_acc;
    end
  end

  // ----------------------------------------------------------------
  // First-clock mask after deselect
  // ----------------------------------------------------------------
  logic first, next_first;

  always_comb begin
    next_first = first;
    if (start) begin
      next_first = (acc == fbsp_pkg::FBSP_DESEL); // RULE20
    end else if (qualified) begin
      next_first = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin // RULE2
    if (!resetn_i) begin
      first <= 1'b0;
    end else begin
      first <= next_first;
    end
  end

  // ----------------------------------------------------------------
  // Burst base address
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] base, next_base;

  always_comb begin
    next_base = base;
    if (start) begin
      next_base = bus.addr; // RULE4 RULE22
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin // RULE2
    if (!resetn_i) begin
      base <= '0;
    end else begin
      base <= next_base;
    end
  end

  // ----------------------------------------------------------------
  // Beat counter
  // ----------------------------------------------------------------
  logic [BW-1:0] beat, next_beat;

  always_comb begin
    next_beat = beat;
    if (load_edge) begin
      next_beat = fbsp_pkg::BEAT_ZERO;
    end else if (advance_edge) begin
      // Two-bit field wraps by itself
      next_beat = beat + fbsp_pkg::BEAT_ONE; // RULE11 RULE13 RULE14
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin // RULE2
    if (!resetn_i) begin
      beat <= fbsp_pkg::BEAT_ZERO;
    end else begin
      beat <= next_beat;
    end
  end

  // ----------------------------------------------------------------
  // Burst address
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] cur_addr;

  always_comb begin
    cur_addr = base; // RULE22
    if (interleave)
      cur_addr[BW-1:0] = base[BW-1:0] ^ beat; // RULE18
    else
      cur_addr[BW-1:0] = base[BW-1:0] + beat; // RULE19
  end

  // ----------------------------------------------------------------
  // Array, one slice per byte lane
  // ----------------------------------------------------------------
  logic write_beat;
  wire logic [DW-1:0] rd_word;
  wire logic [BYTES-1:0] rd_par;

  // Write data arrives on the edge after its address
  assign write_beat = qualified && (acc == fbsp_pkg::FBSP_WRITE);

  for (genvar g = 0; g < BYTES; g++) begin : g_lane
    logic [LANE_W-1:0] lane_q [DEPTH];
    logic par_q [DEPTH];
    logic lane_we;
    logic [LANE_W-1:0] next_lane;
    logic next_par;

    always_comb begin
      lane_we = write_beat && !bus.byte_lane_select_n[g]; // RULE16
      next_lane = bus.dq[g*LANE_W +: LANE_W];
      next_par = bus.parity_lines[g];
    end

    always_ff @(posedge clk_i) begin
      if (lane_we) begin
        lane_q[cur_addr] <= next_lane;
        par_q[cur_addr] <= next_par;
      end
    end

    assign rd_word[g*LANE_W +: LANE_W] = lane_q[cur_addr];
    assign rd_par[g] = par_q[cur_addr];
  end

  // ----------------------------------------------------------------
  // Flow-through read and output drive
  // ----------------------------------------------------------------
  logic drive;

  // Drive only a settled read, never the first clock of a read started from deselect
  assign drive = (acc == fbsp_pkg::FBSP_READ) && !first; // RULE20
  assign bus.mem_dq = rd_word; // RULE7 RULE9
  assign bus.mem_dqp = rd_par;
  assign bus.mem_oe = drive && !bus.output_drive_n; // RULE8 RULE20
  assign busy_o = (acc != fbsp_pkg::FBSP_DESEL);
endmodule : fbsp_mem

/* hw/fbsp_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module fbsp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = fbsp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr, rd, next_wr, next_rd;
  logic push, pop;

  assign in_ready_o = (wr - rd) != (AW+1)'(DEPTH);
  assign out_valid_o = wr != rd;
  assign out_data_o = store[rd[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_wr = wr + (AW+1)'(push);
    next_rd = rd + (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr <= '0;
      rd <= '0;
    end else begin
      wr <= next_wr;
      rd <= next_rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push)
      store[wr[AW-1:0]] <= in_data_i;
  end
endmodule : fbsp_fifo

/* hw/fbsp_ctl.sv */
// Memory controller end: issues single or burst reads and writes.
// Read data passes through a FIFO; a stalled drain stalls the bus.
`timescale 1ns/1ps
module fbsp_ctl #(
  parameter int ADDR_W = fbsp_pkg::ADDR_W,
  parameter int BYTES = fbsp_pkg::BYTES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Strap choice
  input wire logic mode_i,
  // Command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [1:0] cmd_len_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [BYTES*8-1:0] cmd_wdata_i,
  input wire logic [BYTES-1:0] cmd_lanes_i,
  // Read data
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [BYTES*8-1:0] rd_data_o,
  // Memory bus
  fbsp_bus_if.ctl bus
);
  localparam int DW = BYTES * 8;
  fbsp_pkg::fbsp_cst_t st, next_st;
  logic [1:0] left, next_left;
  logic wr, next_wr, rdp, next_rdp;
  logic [DW-1:0] wdat, next_wdat;
  logic [BYTES-1:0] lanes, next_lanes;
  logic fifo_ready, stall;

  // Stall the bus while a read could not be stored
  assign stall = !fifo_ready;
  assign cmd_ready_o = !stall && st != fbsp_pkg::FBSP_C_BURST;
  assign bus.clock_qualifier_n = stall; // RULE21
  assign bus.mode = mode_i;
  assign bus.select_a_n = !(cmd_valid_i && cmd_ready_o);
  assign bus.select_b = 1'b1;
  assign bus.select_c_n = 1'b0;
  assign bus.advance_or_load = (st == fbsp_pkg::FBSP_C_BURST); // RULE12
  assign bus.write_n = !cmd_write_i; // RULE6
  assign bus.addr = cmd_addr_i;
  assign bus.output_drive_n = 1'b0; // RULE8
  assign bus.byte_lane_select_n = ~lanes;
  assign bus.ctl_dq = wdat;
  assign bus.ctl_dqp = '0;
  assign bus.ctl_oe = wr;

  always_comb begin
    next_st = st;
    next_left = left;
    next_wr = wr;
    next_rdp = 1'b0;
    next_wdat = wdat;
    next_lanes = lanes;
    if (!stall) begin
      next_wr = 1'b0;
      next_lanes = '0;
      unique case (st)
        fbsp_pkg::FBSP_C_IDLE, fbsp_pkg::FBSP_C_CMD: begin
          if (cmd_valid_i) begin // RULE9
            next_wr = cmd_write_i;
            next_rdp = !cmd_write_i;
            next_wdat = cmd_wdata_i;
            next_lanes = cmd_write_i ? cmd_lanes_i : '0;
            next_left = cmd_len_i;
            next_st = (cmd_len_i != 2'h0) ? fbsp_pkg::FBSP_C_BURST
                                          : fbsp_pkg::FBSP_C_CMD;
          end else
            next_st = fbsp_pkg::FBSP_C_IDLE;
        end
        fbsp_pkg::FBSP_C_BURST: begin
          next_wr = wr;
          next_rdp = rdp;
          next_lanes = lanes;
          next_wdat = wdat + DW'(1);
          next_left = left - 2'h1;
          next_st = (left == 2'h1) ? fbsp_pkg::FBSP_C_CMD
                                   : fbsp_pkg::FBSP_C_BURST;
        end
        default: next_st = fbsp_pkg::FBSP_C_IDLE;
      endcase
    end else
      next_rdp = rdp;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= fbsp_pkg::FBSP_C_IDLE;
      left <= 2'h0;
      wr <= 1'b0;
      rdp <= 1'b0;
      wdat <= '0;
      lanes <= '0;
    end else begin
      st <= next_st;
      left <= next_left;
      wr <= next_wr;
      rdp <= next_rdp;
      wdat <= next_wdat;
      lanes <= next_lanes;
    end
  end

  fbsp_fifo #(.WIDTH(DW), .DEPTH(fbsp_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(rdp && !stall),
    .in_ready_o(fifo_ready),
    .in_data_i(bus.dq),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );
endmodule : fbsp_ctl

/* sim/fbsp_sva.sv */
// Checker on the bus between controller and memory port.
// Assumes the bench wires it to the bus signals by name.
`timescale 1ns/1ps
module fbsp_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Controller drive
  input wire logic clock_qualifier_n,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic select_c_n,
  input wire logic advance_or_load,
  input wire logic write_n,
  input wire logic output_drive_n,
  input wire logic ctl_oe,
  // Memory drive
  input wire logic [fbsp_pkg::DATA_W-1:0] mem_dq,
  input wire logic mem_oe
);
  logic sel_all;
  logic last_sel;
  logic next_last_sel;
  assign sel_all = !select_a_n && select_b && !select_c_n;
  // Selected at the last load edge
  always_comb begin
    next_last_sel = last_sel;
    if (!clock_qualifier_n && !advance_or_load) next_last_sel = sel_all;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) last_sel <= 1'b0;
    else last_sel <= next_last_sel;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd;
    !clock_qualifier_n && !advance_or_load && sel_all && write_n;
  endsequence
  sequence s_wr;
    !clock_qualifier_n && !advance_or_load && sel_all && !write_n;
  endsequence
  sequence s_desel;
    !clock_qualifier_n && !advance_or_load && !sel_all;
  endsequence
  sequence s_adv;
    !clock_qualifier_n && advance_or_load;
  endsequence
  a_desel_float: assert property (s_desel |=> !mem_oe)
    else $error("memory drives bus after deselect");
  a_write_float: assert property (s_wr |=> !mem_oe)
    else $error("memory drives bus in write data cycle");
  a_first_mask: assert property (!last_sel ##0 s_rd |=> !mem_oe)
    else $error("memory drives first cycle after deselect");
  a_read_drive: assert property (
    last_sel ##0 s_rd ##1 !output_drive_n |-> mem_oe)
    else $error("read data not driven in its cycle");
  a_burst_drive: assert property (
    last_sel ##0 s_rd ##1 s_adv ##1 !output_drive_n |-> mem_oe)
    else $error("read burst beat not driven");
  a_wburst_float: assert property (s_wr ##1 s_adv |=> !mem_oe)
    else $error("memory drives during write burst");
  a_no_fight: assert property (!(mem_oe && ctl_oe))
    else $error("both ends drive the data lines");
  a_freeze_data: assert property (
    clock_qualifier_n && mem_oe |=> !mem_oe || $stable(mem_dq))
    else $error("read data changed on a masked edge");
  a_load_after_desel: assert property (
    s_desel ##1 !clock_qualifier_n |-> !advance_or_load)
    else $error("advance driven right after deselect");
  a_mask_one_clk: assert property (
    !last_sel ##0 s_rd ##1 s_adv ##1 !output_drive_n |-> mem_oe)
    else $error("read burst beat masked past first clock");
endmodule : fbsp_sva

/* sim/fbsp_bench.sv */
// Bench joining memory port and controller over their bus.
// Assumes package, bus interface and checker compiled first.
`timescale 1ns/1ps
module fbsp_bench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mode_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_write_i = 1'b0;
  logic [1:0] cmd_len_i = 2'h0;
  logic [9:0] cmd_addr_i = 10'h000;
  logic [31:0] cmd_wdata_i = 32'h0000_0000;
  logic [3:0] cmd_lanes_i = 4'h0;
  logic rd_ready_i = 1'b0;
  logic cmd_ready_o;
  logic rd_valid_o;
  logic busy_o;
  logic [31:0] rd_data_o;
  logic [31:0] ref_mem [1024];
  logic [31:0] got [$];
  logic [31:0] want [$];
  logic [3:0] rgn;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 63398;
  bit hold = 1'b0;
  bit fill_done = 1'b0;
  always #5 clk_i = ~clk_i;
  fbsp_bus_if bus ();
  fbsp_mem fbsp_mem_inst (.clk_i(clk_i), .resetn_i(resetn_i), .bus(bus),
    .busy_o(busy_o));
  fbsp_ctl fbsp_ctl_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_i(mode_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_write_i(cmd_write_i), .cmd_len_i(cmd_len_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_lanes_i(cmd_lanes_i), .rd_valid_o(rd_valid_o),
    .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .bus(bus));
  fbsp_sva fbsp_sva_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .clock_qualifier_n(bus.clock_qualifier_n), .select_a_n(bus.select_a_n),
    .select_b(bus.select_b), .select_c_n(bus.select_c_n),
    .advance_or_load(bus.advance_or_load), .write_n(bus.write_n),
    .output_drive_n(bus.output_drive_n), .ctl_oe(bus.ctl_oe),
    .mem_dq(bus.mem_dq), .mem_oe(bus.mem_oe));
  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] beat(logic [9:0] a, int i);
    return {a[9:2], mode_i ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
  endfunction : beat
  function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] l);
    for (int b = 0; b < 4; b++) if (l[b]) o[b*8+:8] = n[b*8+:8];
    return o;
  endfunction : merge
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Command and drain drivers
  // ----------------------------------------------------------------
  task automatic issue(bit w, logic [1:0] n, logic [9:0] a, logic [31:0] d,
    logic [3:0] l);
    @(negedge clk_i);
    {cmd_valid_i, cmd_write_i, cmd_len_i, cmd_addr_i, cmd_wdata_i,
      cmd_lanes_i} = {1'b1, w, n, a, d, l};
    for (int i = 0; i <= n; i++) begin
      if (w) ref_mem[beat(a, i)] = merge(ref_mem[beat(a, i)], d + i, l);
      else want.push_back(ref_mem[beat(a, i)]);
    end
    #1;
    while (cmd_ready_o !== 1'b1) #10;
    @(posedge clk_i);
  endtask : issue
  // First beat of a stream follows writes or idle and is discarded
  task automatic flush;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    repeat (3000) if (got.size() < want.size()) @(negedge clk_i);
    @(negedge clk_i);
    check("beats", want.size(), got.size());
    check("drained", 0, rd_valid_o);
    check("idle busy", 0, busy_o);
    void'(got.pop_front());
    void'(want.pop_front());
    foreach (want[i]) check("read data", want[i], got[i]);
    got.delete();
    want.delete();
  endtask : flush
  always @(negedge clk_i) begin
    bit r;
    r = !hold && ($random(seed) % 4 != 0);
    rd_ready_i = r;
    if (r && rd_valid_o === 1'b1) got.push_back(rd_data_o);
  end
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode_i = m[0];
      rgn = 4'($random(seed));
      for (int k = 0; k < 16; k++)
        issue(1, 2'h3, {rgn, 4'(k), 2'(k)}, $random(seed), 4'hf);
      issue(0, 2'h0, {rgn, 6'h00}, 32'h0000_0000, 4'h0);
      for (int j = 0; j < 24; j++)
        issue(1'($random(seed)), 2'($random(seed)), {rgn, 6'($random(seed))},
          $random(seed), 4'($random(seed)));
      flush();
      $display("test burst mode %0d done", m);
    end
    hold = 1'b1;
    fork
      begin
        for (int j = 0; j < 12; j++) issue(0, 2'h3, {rgn, 6'($random(seed))},
          32'h0000_0000, 4'h0);
        fill_done = 1'b1;
      end
      begin
        repeat (300) @(negedge clk_i);
        check("stalled", 0, fill_done);
        check("busy stalled", 1, busy_o);
        hold = 1'b0;
      end
    join
    flush();
    $display("test fifo fill done");
    close_out();
  end
  // Far beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
endmodule : fbsp_bench
